// [bench/downconversion_path_tb.sv]
/*
 * self-checking bench for the down-conversion path: bypass, fifo, real and complex runs.
 * assumes the stream partner model and a 100 mhz core_clk.
 */
`timescale 1ns/1ns
module downconversion_path_tb
    import downconv_pkg::*;
;
    logic core_clk = 1'b0, rst = 1'b1, stall = 1'b0; // clock, reset, sink stall
    logic path_enable = 1'b0, complex_mode = 1'b0, gain_enable = 1'b0;
    logic quarter_mix = 1'b0, phase_invert = 1'b0, mixer_restart = 1'b0, powerdown_align_pin = 1'b0;
    logic [2:0] decim_log2 = 3'h1, res_sel = 3'h6;
    logic [FREQ_W-1:0] freq_word = 32'h0;
    logic [SAMPLE_W-1:0] sample_in;
    logic sample_valid, sample_ready, out_is_q, out_valid, out_ready;
    logic [CALC_W-1:0] out_data;
    int err_count = 0, checks_done = 0, cycles = 0, t0;
    // clock
    initial begin
        forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
    end
    downconversion_path downconversion_path_i (.core_clk(core_clk), .rst(rst), .sample_in(sample_in),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .path_enable(path_enable),
        .complex_mode(complex_mode), .decim_log2(decim_log2), .gain_enable(gain_enable),
        .quarter_mix(quarter_mix), .phase_invert(phase_invert), .res_sel(res_sel), .freq_word(freq_word),
        .mixer_restart(mixer_restart), .powerdown_align_pin(powerdown_align_pin), .out_data(out_data),
        .out_is_q(out_is_q), .out_valid(out_valid), .out_ready(out_ready));
    stream_partner stream_partner_i (.core_clk(core_clk), .rst(rst), .stall(stall), .sample_in(sample_in),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .out_data(out_data), .out_is_q(out_is_q),
        .out_valid(out_valid), .out_ready(out_ready));
    // verdict and end of run
    task automatic close_out();
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one comparison
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // send n samples alternating a and b, then expect w words
    task automatic go(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b, input int n, input int w);
        stream_partner_i.got.delete();
        for (int i = 0; i < n; i++) stream_partner_i.put(i % 2 ? b : a);
        stream_partner_i.idle();
        repeat (40) @(posedge core_clk);
        chk("word count", stream_partner_i.got.size(), w);
    endtask
    // compare a logged word
    task automatic word(input int i, input logic q, input logic [CALC_W-1:0] v);
        chk("word", stream_partner_i.got[i], {q, v});
    endtask
    // restart toggle, then let the event land
    task automatic restart();
        mixer_restart <= ~mixer_restart;
        repeat (4) @(posedge core_clk);
    endtask
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("out_valid", out_valid, 0);
        // bypass: one left-justified word per sample
        go(14'h1abc, 14'h2001, 2, 2);
        word(0, 0, 20'h6af00);
        word(1, 0, 20'h80040);
        // fifo filled until refused, then drained in order
        stall <= 1'b1;
        t0 = stream_partner_i.taken;
        stream_partner_i.got.delete();
        fork
            begin
                for (int i = 1; i <= 10; i++) stream_partner_i.put(14'(i));
                stream_partner_i.idle();
            end
        join_none
        repeat (40) @(posedge core_clk);
        // the output register holds one word beyond the full fifo
        chk("refused when full", 32'((stream_partner_i.taken - t0) == FIFO_DEPTH + 1 && sample_ready === 1'b0), 1);
        stall <= 1'b0;
        wait fork;
        repeat (40) @(posedge core_clk);
        for (int i = 0; i < 10; i++) word(i, 0, CALC_W'(i + 1) << SAMPLE_PAD);
        // real mode, every factor: rate and low-pass of a constant
        path_enable <= 1'b1;
        freq_word <= 32'h0;
        for (int d = 1; d <= 5; d++) begin
            decim_log2 <= 3'(d);
            restart();
            go(14'h0400, 14'h0400, 32, 32 >> d);
            word(0, 0, 20'h10000);
        end
        // a factor code out of range acts as factor 2
        decim_log2 <= 3'h7;
        restart();
        go(14'h0400, 14'h0400, 4, 2);
        word(1, 0, 20'h10000);
        decim_log2 <= 3'h1;
        gain_enable <= 1'b1;
        restart();
        go(14'h0400, 14'h0400, 2, 1);
        word(0, 0, 20'h16800);
        gain_enable <= 1'b0;
        // averaging keeps 20 bits; output truncated to 14 + min(res_sel, 6) bits
        for (int r = 0; r < 8; r++) begin
            res_sel <= 3'(r);
            restart();
            go(14'h0100, 14'h0101, 2, 1);
            word(0, 0, 20'h04020 & ~((20'h1 << (6 - (r > 6 ? 6 : r))) - 20'h1));
        end
        // complex, frequency zero: i carries the scaled sample, q is zero
        complex_mode <= 1'b1;
        restart();
        go(14'h0400, 14'h0400, 2, 2);
        word(0, 0, 20'h0ffe0);
        word(1, 1, 20'h0);
        gain_enable <= 1'b1;
        restart();
        go(14'h0400, 14'h0400, 2, 2);
        word(0, 0, 20'h1ffc0);
        gain_enable <= 1'b0;
        // half-rate word stays pending until the restart toggle
        freq_word <= 32'h80000000;
        go(14'h0400, 14'h0400, 2, 2);
        word(0, 0, 20'h0ffe0);
        restart();
        go(14'h0400, 14'h0400, 2, 2);
        word(0, 0, 20'h0);
        // align pin reloads the zero word
        freq_word <= 32'h0;
        powerdown_align_pin <= 1'b1;
        repeat (2) @(posedge core_clk);
        powerdown_align_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        go(14'h0400, 14'h0400, 2, 2);
        word(0, 0, 20'h0ffe0);
        // quarter turn: sign of q follows the exponent
        freq_word <= 32'h40000000;
        restart();
        go(14'h0400, 14'h0400, 2, 2);
        word(1, 1, 20'h07ff0);
        phase_invert <= 1'b1;
        restart();
        go(14'h0400, 14'h0400, 2, 2);
        word(1, 1, 20'hf8010);
        // quarter-rate mix: i, -q, -i, q as real words
        phase_invert <= 1'b0;
        freq_word <= 32'h0;
        quarter_mix <= 1'b1;
        restart();
        go(14'h0400, 14'h0400, 4, 4);
        word(0, 0, 20'h0ffe0);
        word(2, 0, 20'hf0020);
        word(3, 0, 20'h0);
        close_out();
    end
endmodule

// [bench/stream_partner.sv]
/*
 * model of the converter core that offers samples and of the formatter that takes words.
 * assumes it shares core_clk with the path and is steered by the bench through put, idle and stall.
 */
`timescale 1ns/1ns
module stream_partner
    import downconv_pkg::*;
(
    // clock, reset and bench control
    input wire logic core_clk,
    input wire logic rst,
    input wire logic stall,
    // sample side
    output logic [SAMPLE_W-1:0] sample_in,
    output logic sample_valid,
    input wire logic sample_ready,
    // word side
    input wire logic [CALC_W-1:0] out_data,
    input wire logic out_is_q,
    input wire logic out_valid,
    output logic out_ready
);
    logic [WORD_W-1:0] got[$]; // accepted words, {is_q, data}
    int taken = 0; // samples accepted by the path
    // quiet lines at time zero
    initial begin
        sample_in = 14'h0;
        sample_valid = 1'b0;
        out_ready = 1'b0;
    end
    // offer one sample and hold it until the edge that sees ready high
    task automatic put(input logic [SAMPLE_W-1:0] s);
        sample_in <= s;
        sample_valid <= 1'b1;
        do @(negedge core_clk); while (sample_ready !== 1'b1);
        @(posedge core_clk);
        taken++;
    endtask
    // release the lines; released data shows the inverse of its last value
    task automatic idle();
        sample_valid <= 1'b0;
        sample_in <= ~sample_in;
    endtask
    // formatter: log each accepted word, stall when asked
    always @(posedge core_clk) begin
        if (!rst && out_valid === 1'b1 && out_ready) begin
            got.push_back({out_is_q, out_data});
        end
        out_ready <= ~stall;
    end
endmodule

// [logic/downconv_pkg.sv]
/*
 * constants shared by the down-conversion path and its fifo.
 * assumes one 100 mhz core clock and a synchronous active-high reset.
 */
package downconv_pkg;
    // clock figures
    localparam int CLK_PERIOD_NS = 10;                  // core_clk period
    // widths
    localparam int SAMPLE_W = 14;                       // converter sample width
    localparam int CALC_W = 20;                         // internal filter precision
    localparam int ACC_W = 25;                          // accumulator, 20 bits plus log2(32)
    localparam int FREQ_W = 32;                         // oscillator frequency word
    localparam int LUT_ADDR_W = 6;                      // phase bits used for sine and cosine
    localparam int LUT_W = 12;                          // signed sine/cosine amplitude
    localparam int LUT_SHIFT = 11;                      // product scaling back to 20 bits
    localparam int SAMPLE_PAD = CALC_W - SAMPLE_W;      // left justification of the sample
    localparam int WORD_W = CALC_W + 1;                 // fifo word: q flag and data
    // decimation and resolution encodings
    localparam logic [2:0] DECIM_LOG2_MIN = 3'h1;       // factor 2
    localparam logic [2:0] DECIM_LOG2_MAX = 3'h5;       // factor 32
    localparam logic [2:0] RES_SEL_MAX = 3'h6;          // 14 + 6 = 20 bit output
    localparam int RES_MIN = 14;                        // narrowest output resolution
    // fifo
    localparam int FIFO_DEPTH = 8;                      // words in the output fifo
    localparam int FIFO_LVL_W = 4;                      // level counter width
    localparam logic [FIFO_LVL_W-1:0] READY_LEVEL = 4'h5; // leave room for three words
    // reset values
    localparam logic [FREQ_W-1:0] FREQ_RESET = 32'h0;   // oscillator idle at reset
    localparam logic [FREQ_W-1:0] PHASE_RESET = 32'h0;  // accumulator phase at reset
endpackage

// [logic/downconversion_path.sv]
/*
 * optional digital down-conversion path: nco mixer, decimating filter, gain,
 * quarter-rate real output and truncation, feeding an 8-word output fifo.
 * assumes samples arrive on core_clk from the converter core, configuration
 * inputs are static or come from logic on core_clk, and the align pin is
 * asynchronous.
 */
`timescale 1ns/1ns
// Function
// - path off unless enabled; factors 2..32
// - 32-bit nco mixer before zero-centred filter
// - real mode bypasses mixer, low-pass only
// - filter arithmetic carried at 20 bits
// - truncate results to chosen output resolution
// - selectable 6-dB gain in complex mode
// - selectable 3-dB gain in real mode
// - output rate equals input rate over factor
// - quarter-rate mix gives real at double rate
// - complex exponential multiplies each real sample
// - phase invert selects negative exponent
// - frequency word signed over half rate span
// - new word active only after restart toggle or align event
// - align event resets phase, loads word
// - align event resets decimation dividers
module downconversion_path
    import downconv_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // converter sample stream
    input wire logic [SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid,
    output logic sample_ready,
    // configuration
    input wire logic path_enable,
    input wire logic complex_mode,
    input wire logic [2:0] decim_log2,
    input wire logic gain_enable,
    input wire logic quarter_mix,
    input wire logic phase_invert,
    input wire logic [2:0] res_sel,
    input wire logic [FREQ_W-1:0] freq_word,
    input wire logic mixer_restart,
    // synchronisation pin
    input wire logic powerdown_align_pin,
    // formatted output
    output logic [CALC_W-1:0] out_data,
    output logic out_is_q,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic pin_s1;                  // align pin, first stage
        logic pin_s2;                  // align pin, second stage
        logic pin_prev;                // align pin, last seen level
        logic restart_prev;            // restart bit, last seen level
        logic [FREQ_W-1:0] freq_active; // frequency in use
        logic [FREQ_W-1:0] phase;      // phase accumulator
        logic [4:0] cnt;               // decimation divider
        logic signed [ACC_W-1:0] acc_i; // in-phase sum
        logic signed [ACC_W-1:0] acc_q; // quadrature sum
        logic rot;                     // quarter-rate rotation step
        logic push_valid;              // word waiting for the fifo
        logic [WORD_W-1:0] push_data;
        logic pend_valid;              // second word of a pair
        logic [WORD_W-1:0] pend_data;
        logic ready;                   // registered sample_ready
        logic [CALC_W-1:0] odata;      // registered output word
        logic oq;
        logic ovalid;
    } dp_state_t;

    dp_state_t st;
    dp_state_t next_st;
    word_fifo_if #(.W(WORD_W), .LW(FIFO_LVL_W)) fq();

    // output fifo
    word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .port(fq.store)
    );

    // quarter-wave cosine, 17 points over 0..90 degrees
    function automatic logic signed [LUT_W-1:0] quarter_tab(input logic [4:0] k);
        case (k)
            5'h00: quarter_tab = 12'sh7ff;
            5'h01: quarter_tab = 12'sh7f5;
            5'h02: quarter_tab = 12'sh7d8;
            5'h03: quarter_tab = 12'sh7a7;
            5'h04: quarter_tab = 12'sh763;
            5'h05: quarter_tab = 12'sh70d;
            5'h06: quarter_tab = 12'sh6a6;
            5'h07: quarter_tab = 12'sh62e;
            5'h08: quarter_tab = 12'sh5a7;
            5'h09: quarter_tab = 12'sh513;
            5'h0a: quarter_tab = 12'sh471;
            5'h0b: quarter_tab = 12'sh3c5;
            5'h0c: quarter_tab = 12'sh30f;
            5'h0d: quarter_tab = 12'sh252;
            5'h0e: quarter_tab = 12'sh18f;
            5'h0f: quarter_tab = 12'sh0c9;
            default: quarter_tab = 12'sh000;
        endcase
    endfunction

    // full-circle cosine from six phase bits
    function automatic logic signed [LUT_W-1:0] cos_of(input logic [LUT_ADDR_W-1:0] p);
        logic [4:0] i;
        i = {1'b0, p[3:0]};
        case (p[5:4])
            2'h0: cos_of = quarter_tab(i);
            2'h1: cos_of = -quarter_tab(5'h10 - i);
            2'h2: cos_of = -quarter_tab(i);
            default: cos_of = quarter_tab(5'h10 - i);
        endcase
    endfunction

    // scaled product of a 20-bit value and a table entry
    function automatic logic signed [CALC_W-1:0] mix(input logic signed [CALC_W-1:0] x,
                                                     input logic signed [LUT_W-1:0] c);
        logic signed [CALC_W+LUT_W-1:0] prod;
        prod = x * c;
        mix = CALC_W'(prod >>> LUT_SHIFT);
    endfunction

    // clamp a wide value into 20 signed bits
    function automatic logic signed [CALC_W-1:0] sat(input logic signed [CALC_W+1:0] v);
        if (v > (CALC_W+2)'(2**(CALC_W-1) - 1)) begin
            sat = {1'b0, {(CALC_W-1){1'b1}}};
        end else if (v < -(CALC_W+2)'(2**(CALC_W-1))) begin
            sat = {1'b1, {(CALC_W-1){1'b0}}};
        end else begin
            sat = CALC_W'(v);
        end
    endfunction

    // gain, then truncation to the selected resolution
    function automatic logic [CALC_W-1:0] finish(input logic signed [CALC_W-1:0] v,
                                                 input logic g, input logic cplx,
                                                 input logic [2:0] rs);
        logic signed [CALC_W+1:0] w;
        logic signed [CALC_W-1:0] r;
        logic [CALC_W-1:0] mask;
        w = (CALC_W+2)'(v);
        if (g && cplx) begin
            w = w <<< 1;
        end else if (g) begin
            w = w + (w >>> 2) + (w >>> 3) + (w >>> 5);
        end
        r = sat(w);
        mask = {CALC_W{1'b1}} << (CALC_W - RES_MIN - int'(rs > RES_SEL_MAX ? RES_SEL_MAX : rs));
        finish = r & mask;
    endfunction

    logic take;
    logic sync_event;
    logic [2:0] dlog;
    logic [4:0] last_cnt;
    logic signed [CALC_W-1:0] x20;
    logic signed [CALC_W-1:0] mi;
    logic signed [CALC_W-1:0] mq;
    logic signed [LUT_W-1:0] sn;
    logic signed [CALC_W-1:0] yi;
    logic signed [CALC_W-1:0] yq;

    // sample handshake and synchronisation events
    assign take = sample_valid && st.ready;
    assign sync_event = (st.restart_prev != mixer_restart) || (st.pin_s2 && !st.pin_prev);
    assign dlog = (decim_log2 < DECIM_LOG2_MIN || decim_log2 > DECIM_LOG2_MAX) ? DECIM_LOG2_MIN : decim_log2;
    assign last_cnt = 5'((1 << dlog) - 1);
    assign x20 = {sample_in, {SAMPLE_PAD{1'b0}}};
    assign sn = cos_of(st.phase[FREQ_W-1 -: LUT_ADDR_W] - 6'h10);
    // mixer: x times exp(+/- j w n), real mode bypasses it
    assign mi = complex_mode ? mix(x20, cos_of(st.phase[FREQ_W-1 -: LUT_ADDR_W])) : x20;
    assign mq = !complex_mode ? '0 : (phase_invert ? -mix(x20, sn) : mix(x20, sn));
    // dump value of the integrate-and-dump low-pass, divided by the factor
    assign yi = CALC_W'((st.acc_i + ACC_W'(mi)) >>> dlog);
    assign yq = CALC_W'((st.acc_q + ACC_W'(mq)) >>> dlog);

    // next state of the whole path
    always_comb begin
        next_st = st;
        next_st.pin_s1 = powerdown_align_pin;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_prev = st.pin_s2;
        next_st.restart_prev = mixer_restart;
        // fifo accepts the waiting word, then the pair's second word moves up
        if (st.push_valid && fq.push_ready) begin
            next_st.push_valid = st.pend_valid;
            next_st.push_data = st.pend_data;
            next_st.pend_valid = 1'b0;
        end
        if (take && !path_enable) begin
            // path off: sample goes out left-justified at 20 bits, truncated to res_sel
            next_st.push_valid = 1'b1;
            next_st.push_data = {1'b0, finish(x20, 1'b0, 1'b0, res_sel)};
        end else if (take) begin
            // oscillator advances once per sample, wrapping naturally
            next_st.phase = st.phase + st.freq_active;
            if (st.cnt >= last_cnt) begin
                // one output per factor samples
                next_st.cnt = '0;
                next_st.acc_i = '0;
                next_st.acc_q = '0;
                next_st.push_valid = 1'b1;
                if (!complex_mode) begin
                    next_st.push_data = {1'b0, finish(yi, gain_enable, 1'b0, res_sel)};
                end else if (quarter_mix) begin
                    // rotate by quarter turns: I, -Q then -I, Q
                    next_st.rot = !st.rot;
                    next_st.push_data = {1'b0, finish(st.rot ? -yi : yi, gain_enable, 1'b1, res_sel)};
                    next_st.pend_valid = 1'b1;
                    next_st.pend_data = {1'b0, finish(st.rot ? yq : -yq, gain_enable, 1'b1, res_sel)};
                end else begin
                    next_st.push_data = {1'b0, finish(yi, gain_enable, 1'b1, res_sel)};
                    next_st.pend_valid = 1'b1;
                    next_st.pend_data = {1'b1, finish(yq, gain_enable, 1'b1, res_sel)};
                end
            end else begin
                next_st.cnt = st.cnt + 5'h1;
                next_st.acc_i = st.acc_i + ACC_W'(mi);
                next_st.acc_q = st.acc_q + ACC_W'(mq);
            end
        end
        // restart or align: load pending word, zero phase and dividers
        if (sync_event) begin
            next_st.freq_active = freq_word;
            next_st.phase = PHASE_RESET;
            next_st.cnt = '0;
            next_st.acc_i = '0;
            next_st.acc_q = '0;
            next_st.rot = 1'b0;
        end
        next_st.ready = (fq.level <= READY_LEVEL);
        // registered output stage in front of the consumer
        if (!st.ovalid || out_ready) begin
            next_st.ovalid = fq.pop_valid;
            next_st.odata = fq.pop_data[CALC_W-1:0];
            next_st.oq = fq.pop_data[CALC_W];
        end
    end

    // fifo side of the carrier
    assign fq.push_valid = st.push_valid;
    assign fq.push_data = st.push_data;
    assign fq.pop_ready = !st.ovalid || out_ready;
    assign sample_ready = st.ready;
    assign out_data = st.odata;
    assign out_is_q = st.oq;
    assign out_valid = st.ovalid;

    // register the state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
            st.freq_active <= FREQ_RESET;
        end else begin
            st <= next_st;
        end
    end

    // checks
    property p_sync_load;
        @(posedge core_clk) disable iff (rst)
        sync_event |=> (st.phase == PHASE_RESET) && (st.freq_active == $past(freq_word)) && (st.cnt == 5'h0);
    endproperty
    a_sync_load: assert property (p_sync_load) else $error("align event did not reset oscillator");

    property p_freq_hold;
        @(posedge core_clk) disable iff (rst)
        !sync_event |=> $stable(st.freq_active);
    endproperty
    a_freq_hold: assert property (p_freq_hold) else $error("frequency changed without restart");

    property p_phase_step;
        @(posedge core_clk) disable iff (rst)
        (take && path_enable && !sync_event) |=> st.phase == $past(st.phase) + $past(st.freq_active);
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase did not advance by word");

    property p_bypass;
        @(posedge core_clk) disable iff (rst)
        (take && !path_enable && res_sel == RES_SEL_MAX) |=> st.push_valid && st.push_data[CALC_W-1:0] == $past(x20);
    endproperty
    a_bypass: assert property (p_bypass) else $error("disabled path altered the sample");

    property p_cnt_bound;
        @(posedge core_clk) disable iff (rst)
        path_enable && $stable(dlog) |-> st.cnt <= last_cnt;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("divider beyond factor");

    property p_dump;
        @(posedge core_clk) disable iff (rst)
        (take && path_enable && !sync_event && st.cnt == last_cnt) |=> st.push_valid && st.cnt == 5'h0;
    endproperty
    a_dump: assert property (p_dump) else $error("no output at divider end");

    property p_real_single;
        @(posedge core_clk) disable iff (rst)
        (take && path_enable && !complex_mode) |=> !st.pend_valid;
    endproperty
    a_real_single: assert property (p_real_single) else $error("real mode produced a pair");

    property p_pair;
        @(posedge core_clk) disable iff (rst)
        (take && path_enable && complex_mode && !sync_event && st.cnt == last_cnt) |=> st.pend_valid;
    endproperty
    a_pair: assert property (p_pair) else $error("complex output lacks second word");

    property p_ready_margin;
        @(posedge core_clk) disable iff (rst)
        fq.level > READY_LEVEL |=> !sample_ready;
    endproperty
    a_ready_margin: assert property (p_ready_margin) else $error("ready held with fifo nearly full");

    property p_out_hold;
        @(posedge core_clk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_is_q);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output word changed before it was taken");

    property p_idle_phase;
        @(posedge core_clk) disable iff (rst)
        !path_enable && !sync_event |=> $stable(st.phase);
    endproperty
    a_idle_phase: assert property (p_idle_phase) else $error("oscillator moved while path disabled");

    property p_real_no_q;
        @(posedge core_clk) disable iff (rst)
        path_enable && !complex_mode |-> st.acc_q == '0;
    endproperty
    a_real_no_q: assert property (p_real_no_q) else $error("real mode built a quadrature sum");

    // scenarios worth seeing
    c_complex_out: cover property (@(posedge core_clk) disable iff (rst) out_valid && out_is_q);
    c_sync: cover property (@(posedge core_clk) disable iff (rst) sync_event ##1 take);
    c_quarter: cover property (@(posedge core_clk) disable iff (rst) quarter_mix && st.rot && st.push_valid);
    c_bypass: cover property (@(posedge core_clk) disable iff (rst) take && !path_enable);
    c_refused: cover property (@(posedge core_clk) disable iff (rst) sample_valid && !sample_ready);
endmodule

// [logic/word_fifo.sv]
/*
 * synchronous fifo, width and depth as parameters, valid/ready on both sides.
 * assumes depth is a power of two and one clock with synchronous reset.
 */
`timescale 1ns/1ns
module word_fifo
    import downconv_pkg::*;
#(
    parameter int W = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // both sides
    word_fifo_if.store port
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem; // word storage
        logic [AW-1:0] wr;            // write pointer
        logic [AW-1:0] rd;            // read pointer
        logic [AW:0] cnt;             // held words
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic do_push;
    logic do_pop;

    // honest flags straight from the count
    assign port.push_ready = (st.cnt != (AW+1)'(DEPTH));
    assign port.pop_valid = (st.cnt != '0);
    assign port.pop_data = st.mem[st.rd];
    assign port.level = FIFO_LVL_W'(st.cnt);
    assign do_push = port.push_valid && port.push_ready;
    assign do_pop = port.pop_valid && port.pop_ready;

    // next state of pointers and storage
    always_comb begin
        next_st = st;
        if (do_push) begin
            next_st.mem[st.wr] = port.push_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (do_pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    // register the state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// [logic/word_fifo_if.sv]
/*
 * valid/ready carrier between the down-conversion core and its output fifo.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface word_fifo_if #(parameter int W = 21, parameter int LW = 4);
    logic push_valid;       // producer offers a word
    logic push_ready;       // fifo has room
    logic [W-1:0] push_data;
    logic pop_valid;        // fifo holds a word
    logic pop_ready;        // consumer takes it
    logic [W-1:0] pop_data;
    logic [LW-1:0] level;   // words currently held
    modport producer (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data, level);
    modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data, level);
endinterface
